// File: rtl/mqaf_flags.sv
// Active queue flags (output valid, almost full) with Avalon-MM registers
// Overview of operation
// - Every output-register load updates the valid flag on that same edge.
// - Empty status kept per queue; flag shows selected read queue only.
// - After the last word, flag goes high at next read-enabled edge.
// - New read queue shows data and valid flag on third edge.
// - Valid flag changes only on rising clock edges.
// - Writes to non-active read queues update their empty status.
// - Valid flag floats when none of this device's queues is selected.
// - Valid flag driven only when read address top bits match strap ID.
// - Switching among own queues keeps driving, updating to new status.
// - Almost-full kept per queue; flag shows selected write queue only.
// - Offset programmable, or default 8 or 128 after default programming.
// - Each queue has its own offset from zero up to its depth.
// - New write queue shows on almost-full flag at third edge.
// - Almost-full path triple registered: three-cycle delay both ways.
// - Skew violation delays almost-full release by one extra cycle.
// - Almost-full flag changes only on rising clock edges.
// - Reads of non-active write queues update their almost-full status.
// - Per-queue almost-full status bus shows every queue; the active flag is one of its bits.
// - Valid flag active low: low means valid word, high means invalid.
//
// Our own choices: the Avalon-MM register port and the placing of the registers.
module mqaf_flags
    import mqaf_pkg::*;
#(
    parameter int DEPTH = DEPTH_DEF
)
(
    input  wire logic                          sys_clk,
    input  wire logic                          rst_n,
    input  wire logic [mqaf_pkg::ADDR_W-1:0]   avs_address,
    input  wire logic                          avs_read,
    input  wire logic                          avs_write,
    input  wire logic [31:0]                   avs_writedata,
    output logic      [31:0]                   avs_readdata,
    output logic                               avs_waitrequest,
    input  wire logic                          write_en_n,
    input  wire logic [mqaf_pkg::SEL_W-1:0]    write_queue_select,
    input  wire logic                          write_select_strobe,
    input  wire logic                          read_en_n,
    input  wire logic [mqaf_pkg::SEL_W-1:0]    read_queue_select,
    input  wire logic                          read_select_strobe,
    input  wire logic                          device_id_strap_0,
    input  wire logic                          device_id_strap_1,
    input  wire logic                          device_id_strap_2,
    input  wire logic                          read_skew_late,
    output logic                               data_valid_flag_n,
    output logic                               data_valid_flag_oe_n,
    output logic                               almost_full_flag_n,
    output logic      [mqaf_pkg::NUM_Q-1:0]    almost_full_status_bus
);
    import mqaf_pkg::*;

    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    typedef logic [CW-1:0]     mqaf_cnt_t;
    typedef logic [QSEL_W-1:0] mqaf_q_t;

    // Defaults beyond the queue depth saturate, else the cast would wrap
    localparam mqaf_cnt_t OFS_SMALL_C = (OFS_SMALL > DEPTH) ? DEPTH_C
                                                            : CW'(OFS_SMALL);
    localparam mqaf_cnt_t OFS_LARGE_C = (OFS_LARGE > DEPTH) ? DEPTH_C
                                                            : CW'(OFS_LARGE);

    function automatic mqaf_q_t qidx(input logic [SEL_W-1:0] sel);
        return sel[QSEL_W-1:0];
    endfunction

    function automatic logic [ID_W-1:0] qid(input logic [SEL_W-1:0] sel);
        return sel[SEL_W-1:SEL_ID_LSB];
    endfunction

    // ************************************************************
    // Queue selection pipelines
    // ************************************************************
    wire logic [ID_W-1:0] strap_id = {device_id_strap_2, device_id_strap_1,
                                      device_id_strap_0};

    logic [SWITCH_LAT-1:0] rsw_v_q;
    mqaf_q_t               rsw_q_q [SWITCH_LAT];
    logic [SWITCH_LAT-1:0] wsw_v_q;
    mqaf_q_t               wsw_q_q [SWITCH_LAT];
    mqaf_q_t               rd_q_q;
    mqaf_q_t               wr_q_q;
    logic                  rd_mine_q;
    logic                  wr_mine_q;

    wire logic rd_take = rsw_v_q[SWITCH_LAT-1];
    wire logic wr_take = wsw_v_q[SWITCH_LAT-1];
    wire mqaf_q_t rd_cur = rd_take ? rsw_q_q[SWITCH_LAT-1] : rd_q_q;
    wire logic rsel_mine = qid(read_queue_select) == strap_id;
    wire logic wsel_mine = qid(write_queue_select) == strap_id;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rsw_v_q <= '0;
            wsw_v_q <= '0;
            for (int i = 0; i < SWITCH_LAT; i++)
            begin
                rsw_q_q[i] <= '0;
                wsw_q_q[i] <= '0;
            end
        end
        else
        begin
            rsw_v_q <= {rsw_v_q[SWITCH_LAT-2:0],
                        read_select_strobe & rsel_mine};
            wsw_v_q <= {wsw_v_q[SWITCH_LAT-2:0],
                        write_select_strobe & wsel_mine};
            rsw_q_q[0] <= qidx(read_queue_select);
            wsw_q_q[0] <= qidx(write_queue_select);
            for (int i = 1; i < SWITCH_LAT; i++)
            begin
                rsw_q_q[i] <= rsw_q_q[i-1];
                wsw_q_q[i] <= wsw_q_q[i-1];
            end
        end
    end

    // write queue committed on third edge
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_q_q <= '0;
            wr_q_q <= '0;
        end
        else
        begin
            rd_q_q <= rd_cur;
            if (wr_take)
                wr_q_q <= wsw_q_q[SWITCH_LAT-1];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rd_mine_q <= 1'b0;
            wr_mine_q <= 1'b0;
        end
        else
        begin
            if (read_select_strobe)
                rd_mine_q <= rsel_mine;
            if (write_select_strobe)
                wr_mine_q <= wsel_mine;
        end
    end

    // ************************************************************
    // Per-queue occupancy
    // ************************************************************
    mqaf_cnt_t       cnt_q [NUM_Q];
    logic [NUM_Q-1:0] empty;
    logic            ov_q;

    wire logic rd_load = rd_take | ~read_en_n | ov_q;
    wire logic cur_empty = empty[rd_cur];
    wire logic rd_pop = rd_mine_q & rd_load & ~cur_empty;
    wire logic wr_push = wr_mine_q & ~write_en_n & (cnt_q[wr_q_q] != DEPTH_C);

    // per-queue counts, reads and writes apply to any queue
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i < NUM_Q; i++)
                cnt_q[i] <= '0;
        end
        else
        begin
            for (int i = 0; i < NUM_Q; i++)
                cnt_q[i] <= cnt_q[i]
                    + CW'(wr_push && wr_q_q == mqaf_q_t'(i))
                    - CW'(rd_pop && rd_cur == mqaf_q_t'(i));
        end
    end

    always_comb
    begin
        for (int i = 0; i < NUM_Q; i++)
            empty[i] = cnt_q[i] == '0;
    end

    // flag loads with the output register
    // empty queue on an enabled read raises the flag
    // register only, so it moves on clock edges
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            ov_q <= 1'b1;
        else if (rd_load)
            ov_q <= cur_empty;
    end

    // own queue switches keep the driver on
    assign data_valid_flag_oe_n = ~rd_mine_q;
    assign data_valid_flag_n    = ov_q;

    // ************************************************************
    // Almost-full boundaries and registers
    // ************************************************************
    logic [1:0]      ctrl_q;
    mqaf_cnt_t       ofs_q [NUM_Q];
    logic [NUM_Q-1:0] af_raw;
    logic [NUM_Q-1:0] af_s_q [AF_STAGES+1];
    logic [NUM_Q-1:0] late_q;

    wire mqaf_cnt_t def_ofs = ctrl_q[CTRL_DEF_BIG] ? OFS_LARGE_C
                                                  : OFS_SMALL_C;

    always_comb
    begin
        for (int i = 0; i < NUM_Q; i++)
            af_raw[i] = ~((DEPTH_C - cnt_q[i]) <=
                          (ctrl_q[CTRL_USE_DEF] ? def_ofs : ofs_q[i]));
    end

    // three stages from count to flag
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (int i = 0; i <= AF_STAGES; i++)
                af_s_q[i] <= '1;
            late_q <= '0;
        end
        else
        begin
            af_s_q[0] <= af_raw;
            for (int i = 1; i <= AF_STAGES; i++)
                af_s_q[i] <= af_s_q[i-1];
            for (int i = 0; i < NUM_Q; i++)
                late_q[i] <= (read_skew_late & rd_pop
                              & rd_cur == mqaf_q_t'(i))
                             | (late_q[i] & ~af_s_q[AF_STAGES-1][i]);
        end
    end

    // late release holds low one more edge
    // status bus carries one bit per queue, the active flag selects one
    assign almost_full_status_bus = af_s_q[AF_STAGES-1]
                                    & (af_s_q[AF_STAGES] | ~late_q);
    // mux of registers, changes on edges only
    assign almost_full_flag_n = almost_full_status_bus[wr_q_q];

    // ************************************************************
    // Avalon-MM slave, one wait state per access
    // ************************************************************
    logic      ack_q;
    wire logic req      = avs_read | avs_write;
    wire logic [ADDR_W-1:0] grp = avs_address & REG_GRP_MASK;
    wire mqaf_q_t ridx  = mqaf_q_t'((avs_address & REG_IDX_MASK) >> IDX_LSB);
    wire logic [1:0] low2 = avs_address[1:0];
    wire logic hit_ofs  = grp == REG_OFS_BASE && low2 == 2'h0;
    wire logic hit_cnt  = grp == REG_CNT_BASE && low2 == 2'h0;
    wire logic [31:0] status_word =
        (32'(empty) << ST_EMPTY_LSB)
        | (32'(almost_full_status_bus) << ST_AF_LSB)
        | (32'(ov_q) << ST_OV_BIT)
        | (32'(af_s_q[AF_STAGES-1][wr_q_q]) << ST_AF_BIT);
    wire logic [31:0] rd_mux =
        avs_address == REG_CTRL   ? 32'(ctrl_q) :
        avs_address == REG_STATUS ? status_word :
        hit_ofs                   ? 32'(ofs_q[ridx]) :
        hit_cnt                   ? 32'(cnt_q[ridx]) : 32'h0;
    // Writes land only at the edge where waitrequest is sampled low, one edge after the wait state ends
    wire logic wr_go = avs_write & ack_q;

    assign avs_waitrequest = req & ~ack_q;

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ack_q        <= 1'b0;
            avs_readdata <= '0;
        end
        else
        begin
            ack_q <= req & ~ack_q;
            if (avs_read & ~ack_q)
                avs_readdata <= rd_mux;
        end
    end

    // Offsets above depth are clipped so the compare stays meaningful
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            ctrl_q <= CTRL_RESET;
            for (int i = 0; i < NUM_Q; i++)
                ofs_q[i] <= OFS_SMALL_C;
        end
        else if (wr_go)
        begin
            if (avs_address == REG_CTRL)
                ctrl_q <= avs_writedata[1:0];
            if (hit_ofs)
                ofs_q[ridx] <= (avs_writedata > 32'(DEPTH)) ? DEPTH_C
                                            : avs_writedata[CW-1:0];
        end
    end

    // ************************************************************
    // Assertions
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    sequence rd_sel_s;
        read_select_strobe & rsel_mine;
    endsequence

    sequence wr_sel_s;
        write_select_strobe & wsel_mine;
    endsequence

    ov_load_a: assert property (
        rd_load |=> ov_q == $past(cur_empty))
        else $error("valid flag not updated on load");

    last_word_a: assert property (
        !ov_q && !read_en_n && empty[rd_q_q] && !rd_take |=> ov_q)
        else $error("valid flag stayed low after last word");

    rd_switch_a: assert property (
        rd_sel_s |-> ##3 rd_take
            ##1 rd_q_q == $past(qidx(read_queue_select), 4))
        else $error("read switch not on third edge");

    id_drive_a: assert property (
        read_select_strobe |=> data_valid_flag_oe_n == !$past(rsel_mine))
        else $error("valid flag drive does not follow id match");

    other_write_a: assert property (
        wr_push && wr_q_q != rd_cur && !rd_take
            |=> cnt_q[$past(wr_q_q)] == $past(cnt_q[wr_q_q]) + 1'b1
                && ov_q == $past(ov_q) | $past(rd_load))
        else $error("write to other queue lost");

    af_delay_a: assert property (
        $fell(af_raw[0]) |-> ##3 !almost_full_status_bus[0])
        else $error("almost-full assert not three cycles");

    wr_switch_a: assert property (
        wr_sel_s |-> ##3 wr_take
            ##1 wr_q_q == $past(qidx(write_queue_select), 4))
        else $error("write switch not on third edge");

    af_active_a: assert property (
        almost_full_flag_n == almost_full_status_bus[wr_q_q])
        else $error("active almost-full flag mismatch");

    af_late_a: assert property (
        late_q[0] && $rose(af_s_q[AF_STAGES-1][0])
            |-> !almost_full_status_bus[0] ##1 almost_full_status_bus[0])
        else $error("late release not one cycle extra");

endmodule

// File: rtl/mqaf_pkg.sv
// Shared constants for the multi-queue active flag logic
package mqaf_pkg;
    // ************************************************************
    // Geometry and selection address layout
    // ************************************************************
    localparam int          NUM_Q      = 4;
    localparam int          QSEL_W     = 2;
    localparam int          ID_W       = 3;
    localparam int          SEL_W      = QSEL_W + ID_W;
    localparam int          SEL_ID_LSB = QSEL_W;
    localparam int          DEPTH_DEF  = 8192;
    localparam int          SWITCH_LAT = 3;
    localparam int          AF_STAGES  = 3;

    // ************************************************************
    // Register map (byte addresses, one word each)
    // ************************************************************
    localparam int          ADDR_W       = 8;
    localparam logic [7:0]  REG_CTRL     = 8'h00;
    localparam logic [7:0]  REG_STATUS   = 8'h04;
    localparam logic [7:0]  REG_OFS_BASE = 8'h10;
    localparam logic [7:0]  REG_CNT_BASE = 8'h20;
    localparam logic [7:0]  REG_IDX_MASK = 8'h0c;
    localparam logic [7:0]  REG_GRP_MASK = 8'hf0;
    localparam int          IDX_LSB      = 2;

    // Control fields
    localparam int          CTRL_USE_DEF = 0;
    localparam int          CTRL_DEF_BIG = 1;
    localparam logic [1:0]  CTRL_RESET   = 2'h1;

    // Status fields
    localparam int          ST_EMPTY_LSB = 0;
    localparam int          ST_AF_LSB    = 4;
    localparam int          ST_OV_BIT    = 8;
    localparam int          ST_AF_BIT    = 9;

    // Default almost-full offsets
    localparam int          OFS_SMALL    = 8;
    localparam int          OFS_LARGE    = 128;
endpackage

// File: sim/mqaf_ctrl_model.sv
// Behavioural system controller driving the queue write and read ports
module mqaf_ctrl_model
    import mqaf_pkg::*;
(
    input  wire logic                     sys_clk,
    output logic                          write_en_n,
    output logic [mqaf_pkg::SEL_W-1:0]    write_queue_select,
    output logic                          write_select_strobe,
    output logic                          read_en_n,
    output logic [mqaf_pkg::SEL_W-1:0]    read_queue_select,
    output logic                          read_select_strobe
);
    timeunit 1ns;
    timeprecision 1ns;

    initial
    begin
        write_en_n          = 1'b1;
        write_queue_select  = '0;
        write_select_strobe = 1'b0;
        read_en_n           = 1'b1;
        read_queue_select   = '0;
        read_select_strobe  = 1'b0;
    end

    // ************************************************************
    // Port tasks, each returns at the edge that takes its request
    // ************************************************************
    // one select strobe pulse, on the read port or the write port
    task automatic sel(input bit rd, input logic [SEL_W-1:0] s);
        @(posedge sys_clk);
        read_queue_select   <= rd ? s : read_queue_select;
        read_select_strobe  <= rd;
        write_queue_select  <= rd ? write_queue_select : s;
        write_select_strobe <= !rd;
        @(posedge sys_clk);
        read_select_strobe  <= 1'b0;
        write_select_strobe <= 1'b0;
    endtask

    // Enable held low for n edges, one word per edge
    task automatic xfer(input bit rd, input int n);
        @(posedge sys_clk);
        read_en_n  <= !rd;
        write_en_n <= rd;
        repeat (n) @(posedge sys_clk);
        read_en_n  <= 1'b1;
        write_en_n <= 1'b1;
    endtask
endmodule

// File: sim/testbench.sv
// Self-checking bench for the multi-queue active flag logic
module testbench;
    timeunit 1ns;
    timeprecision 1ns;
    import mqaf_pkg::*;
    localparam int DEPTH = 16;
    logic              sys_clk = 1'b0;
    logic              rst_n = 1'b0;
    logic [ADDR_W-1:0] avs_address = '0;
    logic              avs_read = 1'b0;
    logic              avs_write = 1'b0;
    logic [31:0]       avs_writedata = '0;
    logic [31:0]       avs_readdata;
    logic              avs_waitrequest;
    logic              write_en_n;
    logic              write_select_strobe;
    logic              read_en_n;
    logic              read_select_strobe;
    logic [SEL_W-1:0]  write_queue_select;
    logic [SEL_W-1:0]  read_queue_select;
    logic [2:0]        id = '0;
    logic [2:0]        other_id = '0;
    logic              read_skew_late = 1'b0;
    logic              data_valid_flag_n;
    logic              data_valid_flag_oe_n;
    logic              almost_full_flag_n;
    logic [NUM_Q-1:0]  almost_full_status_bus;
    logic [NUM_Q-1:0]  afv;
    logic [31:0]       rd;
    int                err_total = 0;
    int                total_checks = 0;
    int                cycles = 0;
    int                cnt [NUM_Q] = '{default: 0};
    int                ofs [NUM_Q] = '{3, 0, 15, 16};
    int                nw [3] = '{2, 1, 13};

    always #20 sys_clk = ~sys_clk;

    mqaf_flags #(.DEPTH(DEPTH)) uut (
        .sys_clk, .rst_n, .avs_address, .avs_read, .avs_write,
        .avs_writedata, .avs_readdata, .avs_waitrequest, .write_en_n,
        .write_queue_select, .write_select_strobe, .read_en_n,
        .read_queue_select, .read_select_strobe,
        .device_id_strap_0(id[0]), .device_id_strap_1(id[1]),
        .device_id_strap_2(id[2]), .read_skew_late, .data_valid_flag_n,
        .data_valid_flag_oe_n, .almost_full_flag_n, .almost_full_status_bus
    );

    mqaf_ctrl_model ctrl (
        .sys_clk, .write_en_n, .write_queue_select, .write_select_strobe,
        .read_en_n, .read_queue_select, .read_select_strobe
    );

    // ************************************************************
    // Reference model, checking and bus tasks
    // ************************************************************
    function automatic logic [NUM_Q-1:0] af_vec();
        logic [NUM_Q-1:0] v;
        for (int q = 0; q < NUM_Q; q++)
            v[q] = !(DEPTH - cnt[q] <= ofs[q]);
        return v;
    endfunction

    // Status word: empties, almost-full bus, valid flag, active almost-full
    function automatic logic [31:0] exp_status(input bit ov_n, input int wq);
        logic [NUM_Q-1:0] e;
        logic [NUM_Q-1:0] a;
        for (int q = 0; q < NUM_Q; q++)
            e[q] = (cnt[q] == 0);
        a = af_vec();
        return (32'(e) << ST_EMPTY_LSB) | (32'(a) << ST_AF_LSB)
               | (32'(ov_n) << ST_OV_BIT) | (32'(a[wq]) << ST_AF_BIT);
    endfunction

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] seen, exp);
        total_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Request held until waitrequest is sampled low
    task automatic bus(input bit wr, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge sys_clk);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= wr;
        avs_read      <= !wr;
        do
        begin
            @(posedge sys_clk);
        end
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read  <= 1'b0;
    endtask

    task automatic wt(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask

    // A hang is cut short well past the expected run length
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            err_total++;
            end_of_test();
        end
    end

    initial
    begin
        void'($urandom(13));
        id       = 3'($urandom);
        other_id = id ^ 3'(1 + $urandom % 7);
        repeat (12) @(posedge sys_clk);
        rst_n <= 1'b1;
        wt(1);
        check("valid_flag", data_valid_flag_n, 1);
        check("valid_oe", data_valid_flag_oe_n, 1);
        check("af_bus", almost_full_status_bus, 4'hf);
        bus(0, REG_CTRL, 0, rd);
        check("ctrl", rd, 1);
        bus(0, REG_OFS_BASE, 0, rd);
        check("ofs_reset", rd, OFS_SMALL);
        bus(0, 8'h08, 0, rd);
        check("unmapped", rd, 0);
        // Default of 128 exceeds this depth, so every queue is almost full
        bus(1, REG_CTRL, 3, rd);
        wt(5);
        check("af_def", almost_full_status_bus, 4'h0);
        bus(1, REG_CTRL, 0, rd);
        for (int q = 0; q < NUM_Q; q++)
        begin
            bus(1, REG_OFS_BASE + 8'(4 * q), ofs[q], rd);
            bus(0, REG_OFS_BASE + 8'(4 * q), 0, rd);
            check("ofs_rb", rd, ofs[q]);
        end
        wt(5);
        check("af_ofs", almost_full_status_bus, af_vec());
        $display("test offsets done");
        ctrl.sel(0, {id, 2'd3});
        wt(2);
        check("af_old", almost_full_flag_n, 1);
        wt(1);
        check("af_q3", almost_full_flag_n, 0);
        ctrl.sel(1, {other_id, 2'd0});
        wt(1);
        check("oe_other", data_valid_flag_oe_n, 1);
        ctrl.sel(1, {id, 2'd3});
        wt(1);
        check("oe_own", data_valid_flag_oe_n, 0);
        wt(2);
        check("ov_empty", data_valid_flag_n, 1);
        for (int k = 0; k < 3; k++)
        begin
            ctrl.sel(0, {id, 2'(k == 2 ? 0 : k + 1)});
            wt(2);
            ctrl.xfer(0, nw[k]);
            wt(2);
            check("af_pre", almost_full_status_bus, af_vec());
            cnt[k == 2 ? 0 : k + 1] += nw[k];
            wt(1);
            check("af_post", almost_full_status_bus, af_vec());
            check("ov_q3", data_valid_flag_n, 1);
        end
        afv = af_vec();
        check("af_act", almost_full_flag_n, afv[0]);
        bus(0, REG_STATUS, 0, rd);
        check("status", rd, exp_status(1'b1, 0));
        bus(0, REG_CNT_BASE, 0, rd);
        check("cnt_q0", rd, cnt[0]);
        $display("test write side done");
        ctrl.sel(1, {id, 2'd1});
        wt(1);
        check("oe_keep", data_valid_flag_oe_n, 0);
        wt(1);
        check("ov_prev", data_valid_flag_n, 1);
        wt(1);
        check("ov_new", data_valid_flag_n, 0);
        wt(2);
        check("ov_hold", data_valid_flag_n, 0);
        ctrl.xfer(1, 1);
        wt(0);
        check("ov_last", data_valid_flag_n, 0);
        ctrl.xfer(1, 1);
        wt(0);
        check("ov_drain", data_valid_flag_n, 1);
        cnt[1] -= nw[0];
        $display("test read side done");
        for (int k = 0; k < 2; k++)
        begin
            read_skew_late <= (k == 0);
            ctrl.sel(1, {id, 2'(k == 0 ? 0 : 2)});
            wt(3);
            check("ov_land", data_valid_flag_n, 0);
            read_skew_late <= 1'b0;
            wt(3 - k);
            check("af_hold", almost_full_status_bus, af_vec());
            cnt[k == 0 ? 0 : 2]--;
            wt(1);
            check("af_rel", almost_full_status_bus, af_vec());
        end
        $display("test release done");
        end_of_test();
    end
endmodule
